// File: src/serial_port_pkg.sv
package serial_port_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int LINK_PERIOD_NS = 48;
  // four quarters per serial bit; a longest time rounds down, never below one cycle
  localparam int QUARTER_RAW    = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QUARTER_CYCLES = (QUARTER_RAW < 1) ? 1 : QUARTER_RAW;

  // ---------------------------------------------------------------
  // addresses and subaddresses
  // ---------------------------------------------------------------
  localparam logic [6:0] CHIP_ADDR      = 7'h70;
  localparam logic       DIR_WRITE      = 1'b0;
  localparam logic       DIR_READ       = 1'b1;
  localparam logic [7:0] WR_SUB_MAX     = 8'h0f;
  localparam logic [7:0] RD_SUB_STATUS  = 8'h80;
  localparam logic [7:0] RD_SUB_ADC     = 8'h81;
  localparam logic [7:0] SUB_NARROW_A   = 8'h03;
  localparam logic [7:0] SUB_NARROW_B   = 8'h08;
  localparam logic [7:0] SUB_NARROW_C   = 8'h0d;
  localparam logic [7:0] SUB_NARROW_D   = 8'h0e;
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam logic [1:0] LAST_QUARTER   = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        write;
    logic [7:0]  sub;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    logic        nack;
    logic [7:0]  data;
  } rsp_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SEL_LEAD, ST_START, ST_SEND, ST_ACK_IN,
    ST_RECV, ST_ACK_OUT, ST_STOP, ST_SEL_TRAIL
  } state_t;

  typedef enum logic [2:0] {
    STG_ADDR_W, STG_SUB, STG_ADDR_R, STG_DATA_HI, STG_DATA_LO, STG_READ
  } stage_t;

endpackage

// File: src/link_pacer.sv
module link_pacer
  import serial_port_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
) (
  input  wire logic clk,       // system clock
  input  wire logic rst,       // synchronous reset, high
  input  wire logic restart,   // realign the quarter count
  input  wire logic data_pin,  // raw data line level
  output logic      tick,      // one-cycle pulse at end of a quarter
  output logic      data_sync  // data line after two flops
);

  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        meta;
  logic        next_tick;

  // ---------------------------------------------------------------
  // quarter divider
  // ---------------------------------------------------------------
  always_comb begin
    next_tick = 1'b0;
    next_cnt  = cnt + 16'h0001;
    if (restart) begin
      next_cnt = 16'h0000;
    end else if (cnt == 16'(QUARTER - 1)) begin
      next_cnt  = 16'h0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt       <= 16'h0000;
      tick      <= 1'b0;
      meta      <= 1'b1;
      data_sync <= 1'b1;
    end else begin
      cnt       <= next_cnt;
      tick      <= next_tick;
      meta      <= data_pin;
      data_sync <= meta;
    end
  end

endmodule

// File: src/serial_port_master.sv
// Summary of operation
// - two-wire mode keeps select and strap low
// - data changes only while clock low, except at start and stop
// - every two-wire command opens with start
// - two-wire ninth clock carries the acknowledge
// - two-wire write ends with stop
// - two-wire read: sub, repeated start, read address
// - master releases data line during read
// - three-wire data changes while clock low
// - three-wire write: select, sub, data, release
// - three-wire read returns eight bits MSB first
module serial_port_master
  import serial_port_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
) (
  input  wire logic  SYS_CLK,                   // system clock, 250 MHz
  input  wire logic  RESET,                     // synchronous reset, high
  input  wire logic  MODE_3WIRE,                // protocol wanted for next command
  input  wire logic  CMD_VALID,                 // command offered
  output logic       CMD_READY,                 // command taken when both high
  input  wire cmd_t  CMD,                       // direction, subaddress, data
  output logic       RSP_VALID,                 // one-cycle end of command
  output rsp_t       RSP,                       // read byte and missing acknowledge
  output logic       BUSY,                      // frame in progress
  output logic       PROTOCOL_SELECT_STRAP,     // protocol strap pin
  output logic       BUS_SELECT_N,              // active-low bus select
  output logic       SERIAL_CLOCK_LINE,         // serial clock to device
  input  wire logic  SERIAL_DATA_LINE_I,        // data line level
  output logic       SERIAL_DATA_LINE_O,        // data line drive value
  output logic       SERIAL_DATA_LINE_OE        // data line drive enable
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  state_t     st,    next_st;
  stage_t     stage, next_stage;
  logic [1:0] q,     next_q;
  logic [2:0] bitc,  next_bitc;
  logic [7:0] sh,    next_sh;
  cmd_t       cmd,   next_cmd;
  logic       nack,  next_nack;
  logic       strap, next_strap;
  logic       scl,   next_scl;
  logic       sdo,   next_sdo;
  logic       sdoe,  next_sdoe;
  logic       seln,  next_seln;
  logic       rspv,  next_rspv;
  rsp_t       rsp,   next_rsp;

  logic   tick;
  logic   sda_in;
  logic   accept;
  logic   bit_end;
  state_t adv_st;
  stage_t adv_stage;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic narrow_reg(input logic [7:0] sub);
    narrow_reg = (sub == SUB_NARROW_A) || (sub == SUB_NARROW_B) ||
                 (sub == SUB_NARROW_C) || (sub == SUB_NARROW_D);
  endfunction

  function automatic logic [7:0] byte_for(input stage_t s, input cmd_t c);
    case (s)
      STG_ADDR_W:  byte_for = {CHIP_ADDR, DIR_WRITE};
      STG_ADDR_R:  byte_for = {CHIP_ADDR, DIR_READ};
      STG_SUB:     byte_for = c.sub;
      STG_DATA_HI: byte_for = c.data[15:8];
      STG_DATA_LO: byte_for = c.data[7:0];
      default:     byte_for = 8'h00;
    endcase
  endfunction

  link_pacer #(
    .QUARTER (QUARTER)
  ) pacer (
    .clk       (SYS_CLK),
    .rst       (RESET),
    .restart   (accept),
    .data_pin  (SERIAL_DATA_LINE_I),
    .tick      (tick),
    .data_sync (sda_in)
  );

  assign CMD_READY = (st == ST_IDLE);
  assign accept    = CMD_READY && CMD_VALID;
  assign bit_end   = tick && (q == LAST_QUARTER);
  assign BUSY      = (st != ST_IDLE);

  assign PROTOCOL_SELECT_STRAP = strap;
  assign BUS_SELECT_N          = seln;
  assign SERIAL_CLOCK_LINE     = scl;
  assign SERIAL_DATA_LINE_O    = sdo;
  assign SERIAL_DATA_LINE_OE   = sdoe;
  assign RSP_VALID             = rspv;
  assign RSP                   = rsp;

  // ---------------------------------------------------------------
  // byte sequencing after a finished byte
  // ---------------------------------------------------------------
  always_comb begin
    adv_st    = ST_SEND;
    adv_stage = stage;
    case (stage)
      STG_ADDR_W: adv_stage = STG_SUB;
      STG_SUB: begin
        if (!cmd.write) begin
          if (strap) begin
            adv_st    = ST_RECV;
            adv_stage = STG_READ;
          end else begin
            adv_st    = ST_START;
            adv_stage = STG_ADDR_R;
          end
        end else begin
          // one-byte registers skip the high byte; unknown subaddresses
          // are still sent, the device discards them
          adv_stage = narrow_reg(cmd.sub) ? STG_DATA_LO : STG_DATA_HI;
        end
      end
      STG_DATA_HI: adv_stage = STG_DATA_LO;
      STG_DATA_LO: adv_st    = strap ? ST_SEL_TRAIL : ST_STOP;
      STG_ADDR_R: begin
        adv_st    = ST_RECV;
        adv_stage = STG_READ;
      end
      default: adv_st = ST_STOP;
    endcase
  end

  // ---------------------------------------------------------------
  // next-state and pin values
  // ---------------------------------------------------------------
  always_comb begin
    next_st    = st;
    next_stage = stage;
    next_q     = tick ? q + 2'h1 : q;
    next_bitc  = bitc;
    next_sh    = sh;
    next_cmd   = cmd;
    next_nack  = nack;
    next_strap = strap;
    next_rspv  = 1'b0;
    next_rsp   = rsp;
    // clock rises at quarter 2, so the device samples data set at quarter 0
    next_scl   = q[1];
    next_sdo   = 1'b0;
    next_sdoe  = 1'b0;
    next_seln  = strap ? 1'b0 : 1'b0;

    case (st)
      ST_IDLE: begin
        // strap follows the request only between frames
        next_strap = MODE_3WIRE;
        next_seln  = strap;
        next_scl   = !strap;
        next_q     = 2'h0;
        if (accept) begin
          next_cmd   = CMD;
          next_nack  = 1'b0;
          next_bitc  = 3'h0;
          next_st    = strap ? ST_SEL_LEAD : ST_START;
          next_stage = strap ? STG_SUB : STG_ADDR_W;
          next_sh    = byte_for(strap ? STG_SUB : STG_ADDR_W, CMD);
        end
      end
      ST_SEL_LEAD: begin
        next_scl  = 1'b0;
        next_seln = !q[1];
        if (bit_end) begin
          next_st = ST_SEND;
        end
      end
      ST_START: begin
        next_scl = (q == 2'h1) || (q == 2'h2);
        if (q[1]) begin
          next_sdoe = 1'b1;
        end
        if (bit_end) begin
          next_st   = ST_SEND;
          next_bitc = 3'h0;
          next_sh   = byte_for(stage, cmd);
        end
      end
      ST_SEND: begin
        // data is held for the whole bit, so it only moves while clock is low
        if (strap) begin
          next_sdo  = sh[7];
          next_sdoe = 1'b1;
        end else begin
          next_sdoe = !sh[7];
        end
        if (bit_end) begin
          next_sh   = {sh[6:0], 1'b0};
          next_bitc = bitc + 3'h1;
          if (bitc == LAST_BIT) begin
            if (strap) begin
              next_st    = adv_st;
              next_stage = adv_stage;
              next_sh    = byte_for(adv_stage, cmd);
            end else begin
              next_st = ST_ACK_IN;
            end
          end
        end
      end
      ST_ACK_IN: begin
        if (bit_end) begin
          if (sda_in) begin
            next_nack = 1'b1;
            next_st   = ST_STOP;
          end else begin
            next_st    = adv_st;
            next_stage = adv_stage;
            next_bitc  = 3'h0;
            next_sh    = byte_for(adv_stage, cmd);
          end
        end
      end
      ST_RECV: begin
        // line released for the whole byte; the device shifts it out
        if (bit_end) begin
          next_sh   = {sh[6:0], sda_in};
          next_bitc = bitc + 3'h1;
          if (bitc == LAST_BIT) begin
            next_st = strap ? ST_SEL_TRAIL : ST_ACK_OUT;
          end
        end
      end
      ST_ACK_OUT: begin
        // no acknowledge from us after the read byte
        if (bit_end) begin
          next_st = ST_STOP;
        end
      end
      ST_STOP: begin
        next_scl  = (q != 2'h0);
        next_sdoe = !q[1];
        if (bit_end) begin
          next_st      = ST_IDLE;
          next_rspv    = 1'b1;
          next_rsp     = '{nack: nack, data: sh};
        end
      end
      ST_SEL_TRAIL: begin
        next_scl  = 1'b0;
        next_seln = q[1];
        if (bit_end) begin
          next_st   = ST_IDLE;
          next_rspv = 1'b1;
          next_rsp  = '{nack: 1'b0, data: sh};
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // the device runs off the clock we drive, with no clock of its own,
  // so nothing here waits on it beyond the serial bit timing
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      st    <= ST_IDLE;
      stage <= STG_ADDR_W;
      q     <= 2'h0;
      bitc  <= 3'h0;
      sh    <= 8'h00;
      cmd   <= '0;
      nack  <= 1'b0;
      strap <= 1'b0;
      scl   <= 1'b1;
      sdo   <= 1'b0;
      sdoe  <= 1'b0;
      seln  <= 1'b0;
      rspv  <= 1'b0;
      rsp   <= '0;
    end else begin
      st    <= next_st;
      stage <= next_stage;
      q     <= next_q;
      bitc  <= next_bitc;
      sh    <= next_sh;
      cmd   <= next_cmd;
      nack  <= next_nack;
      strap <= next_strap;
      scl   <= next_scl;
      sdo   <= next_sdo;
      sdoe  <= next_sdoe;
      seln  <= next_seln;
      rspv  <= next_rspv;
      rsp   <= next_rsp;
    end
  end

endmodule

// File: tb/serial_port_master_properties.sv
module serial_port_master_properties
  import serial_port_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
) (
  input wire logic SYS_CLK,  // clock
  input wire logic RESET,    // reset
  input wire logic MODE_3WIRE, // mode
  input wire logic CMD_VALID, // offer
  input wire logic CMD_READY, // taken
  input wire cmd_t CMD,      // command
  input wire logic RSP_VALID, // done
  input wire rsp_t RSP,      // answer
  input wire logic BUSY,     // frame
  input wire logic PROTOCOL_SELECT_STRAP, // strap
  input wire logic BUS_SELECT_N, // select
  input wire logic SERIAL_CLOCK_LINE, // clock
  input wire logic SERIAL_DATA_LINE_I, // line
  input wire logic SERIAL_DATA_LINE_O, // value
  input wire logic SERIAL_DATA_LINE_OE // enable
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SMAX = 4 * QUARTER + 4;
  // ---------------------------------------------------------------
  // rise count since start; ninth rise is the acknowledge slot
  // ---------------------------------------------------------------
  logic       drv;
  logic       scl_q;
  logic       drv_q;
  logic [3:0] rcnt;
  logic [3:0] next_rcnt;
  assign drv = SERIAL_DATA_LINE_OE ? SERIAL_DATA_LINE_O : 1'b1;
  always_comb begin
    next_rcnt = rcnt;
    if (!PROTOCOL_SELECT_STRAP && SERIAL_CLOCK_LINE && scl_q && drv_q && !drv)
      next_rcnt = 4'h0;
    else if (SERIAL_CLOCK_LINE && !scl_q)
      next_rcnt = (rcnt == 4'h8) ? 4'h0 : rcnt + 4'h1;
  end
  always_ff @(posedge SYS_CLK) begin
    rcnt  <= RESET ? 4'h0 : next_rcnt;
    scl_q <= RESET ? 1'b1 : SERIAL_CLOCK_LINE;
    drv_q <= RESET ? 1'b1 : drv;
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  sel_tie_a: assert property (!PROTOCOL_SELECT_STRAP && !$past(PROTOCOL_SELECT_STRAP, 2)
    |-> !BUS_SELECT_N) else $error("select high in two-wire mode");
  start_seen_a: assert property (!PROTOCOL_SELECT_STRAP && CMD_VALID && CMD_READY
    |-> ##[1:SMAX] (SERIAL_CLOCK_LINE && $fell(drv))) else $error("no start");
  stop_done_a: assert property (!PROTOCOL_SELECT_STRAP && SERIAL_CLOCK_LINE
    && $past(SERIAL_CLOCK_LINE) && $rose(drv) |-> ##[0:SMAX] RSP_VALID)
    else $error("stop without end");
  ack_free_a: assert property (!PROTOCOL_SELECT_STRAP && SERIAL_CLOCK_LINE
    && !scl_q && rcnt == 4'h8 |-> drv) else $error("line held in ack slot");
  strap_hold_a: assert property (BUSY && $past(BUSY)
    |-> $stable(PROTOCOL_SELECT_STRAP)) else $error("strap moved in frame");
  sel_idle_a: assert property (PROTOCOL_SELECT_STRAP && $past(PROTOCOL_SELECT_STRAP, 2)
    && BUS_SELECT_N |-> !SERIAL_CLOCK_LINE) else $error("clock while deselected");
  wire3_data_a: assert property (PROTOCOL_SELECT_STRAP && !BUS_SELECT_N
    && SERIAL_CLOCK_LINE && $past(SERIAL_CLOCK_LINE) |-> $stable(drv))
    else $error("data moved with clock high");
  open_drain_a: assert property (!PROTOCOL_SELECT_STRAP && SERIAL_DATA_LINE_OE
    |-> !SERIAL_DATA_LINE_O) else $error("line driven high");
  cover property (CMD_VALID && CMD_READY && MODE_3WIRE);
  cover property (RSP_VALID && RSP.nack);
  cover property (RSP_VALID && !PROTOCOL_SELECT_STRAP && RSP.data != 8'h00);
endmodule
bind serial_port_master serial_port_master_properties #(.QUARTER(QUARTER)) u_props (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .MODE_3WIRE(MODE_3WIRE), .CMD_VALID(CMD_VALID),
  .CMD_READY(CMD_READY), .CMD(CMD), .RSP_VALID(RSP_VALID), .RSP(RSP), .BUSY(BUSY),
  .PROTOCOL_SELECT_STRAP(PROTOCOL_SELECT_STRAP), .BUS_SELECT_N(BUS_SELECT_N),
  .SERIAL_CLOCK_LINE(SERIAL_CLOCK_LINE), .SERIAL_DATA_LINE_I(SERIAL_DATA_LINE_I),
  .SERIAL_DATA_LINE_O(SERIAL_DATA_LINE_O), .SERIAL_DATA_LINE_OE(SERIAL_DATA_LINE_OE));

// File: tb/serial_device_model.sv
module serial_device_model
  import serial_port_pkg::*;
#(
  parameter logic [7:0] STAT_V = 8'h5a,
  parameter logic [7:0] ADC_V  = 8'hc3
) (
  input wire logic strap,    // protocol strap
  input wire logic sel_n,    // select, low active
  input wire logic scl,      // serial clock
  input wire logic sda,      // resolved data line
  input wire logic mute,     // withhold address ack
  output logic     pull_low  // open-drain pull
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // behavioural slave, clocked by the serial clock only
  // ---------------------------------------------------------------
  logic [15:0] mem [0:15];
  logic [7:0]  sr, sub, hold, out;
  logic        rd, hi, ack;
  int          cnt, stage;
  // delayed copy so a data move on the clock's falling edge is not a start
  wire #1 sda_d = sda;
  wire active = strap ? !sel_n : 1'b1;
  initial begin
    pull_low = 0; stage = 4; cnt = 0; rd = 0; hi = 0; sub = 0;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  task automatic take(input logic [7:0] b);
    ack = 1;
    if (rd) begin rd = 0; ack = 0; end
    else case (stage)
      0: begin
        ack = b[7:1] == CHIP_ADDR && !mute;
        rd = ack && b[0] == DIR_READ;
        stage = ack ? (rd ? 3 : 1) : 4;
      end
      1: begin sub = b; stage = 2; hi = 0; rd = strap && b[7]; end
      2: if (!(sub inside {SUB_NARROW_A, SUB_NARROW_B, SUB_NARROW_C, SUB_NARROW_D})
             && !hi) begin hold = b; hi = 1; end
         else begin
           if (sub <= WR_SUB_MAX && !(sub inside {[8'h09:8'h0c]}))
             mem[sub[3:0]] = hi ? {hold, b} : {8'h00, b};
           stage = 3;
         end
      default: ack = 0;
    endcase
    out = (sub == RD_SUB_STATUS) ? STAT_V : ADC_V;
  endtask
  always @(negedge sda_d) if (!strap && scl === 1'b1) begin
    stage = 0; cnt = 0; rd = 0; pull_low = 0;
  end
  always @(posedge sda_d) if (!strap && scl === 1'b1) begin stage = 4; pull_low = 0; end
  always @(negedge sel_n) if (strap) begin stage = 1; cnt = 0; rd = 0; end
  always @(posedge sel_n) if (strap) begin stage = 4; pull_low = 0; end
  always @(posedge scl) if (active && stage != 4 && cnt < 9) begin
    if (cnt < 8) sr = {sr[6:0], sda};
    cnt++;
    if (strap && cnt == 8) begin cnt = 0; take(sr); end
  end
  always @(negedge scl) if (active && stage != 4) begin
    if (cnt == 9) cnt = 0;
    if (!strap && cnt == 8) begin
      if (rd) begin rd = 0; pull_low = 0; end
      else begin take(sr); pull_low = ack; end
    end else pull_low = rd && !out[7 - cnt];
  end
endmodule

// File: tb/serial_port_master_tb_top.sv
module serial_port_master_tb_top
  import serial_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] STAT_V = 8'h5a;
  localparam logic [7:0] ADC_V  = 8'hc3;
  logic sys_clk, reset, mode_3wire, cmd_valid, mute;
  logic cmd_ready, rsp_valid, busy, strap, sel_n, scl, sda_o, sda_oe, pull_low;
  cmd_t cmd;
  rsp_t rsp;
  int   mismatches, n_tests;
  wire  sda = (sda_oe ? sda_o : 1'b1) & ~pull_low;
  serial_port_master uut (
    .SYS_CLK(sys_clk), .RESET(reset), .MODE_3WIRE(mode_3wire), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD(cmd), .RSP_VALID(rsp_valid), .RSP(rsp), .BUSY(busy),
    .PROTOCOL_SELECT_STRAP(strap), .BUS_SELECT_N(sel_n), .SERIAL_CLOCK_LINE(scl),
    .SERIAL_DATA_LINE_I(sda), .SERIAL_DATA_LINE_O(sda_o), .SERIAL_DATA_LINE_OE(sda_oe));
  serial_device_model #(.STAT_V(STAT_V), .ADC_V(ADC_V)) dev (
    .strap(strap), .sel_n(sel_n), .scl(scl), .sda(sda), .mute(mute), .pull_low(pull_low));
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // strap needs idle edges to follow a mode change
  task run(input logic m3, input logic wr, input logic [7:0] sub, input logic [15:0] d);
    int i;
    if (mode_3wire !== m3) begin mode_3wire = m3; repeat (3) @(negedge sys_clk); end
    check({15'h0, strap}, {15'h0, m3});
    i = 0;
    while (cmd_ready !== 1'b1 && i < 50) begin @(negedge sys_clk); i++; end
    // a port that never comes back to idle counts as a failure, not a silent skip
    if (cmd_ready !== 1'b1) begin mismatches++; final_report(); end
    cmd_valid = 1;
    cmd = {wr, sub, d};
    @(negedge sys_clk);
    cmd_valid = 0;
    check({14'h0, busy, cmd_ready}, 16'h0002);
    i = 0;
    while (rsp_valid !== 1'b1 && i < 1000) begin @(negedge sys_clk); i++; end
    if (rsp_valid !== 1'b1) begin mismatches++; final_report(); end
    check({14'h0, busy, cmd_ready}, 16'h0001);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task wr_burst(input logic m3);
    logic [7:0]  subs [6];
    logic [15:0] d;
    subs = '{8'h00, 8'h03, 8'h08, 8'h0d, 8'h0e, 8'h0f};
    foreach (subs[k]) begin
      d = {subs[k] ^ 8'ha5, subs[k] ^ (m3 ? 8'h96 : 8'h3c)};
      run(m3, 1'b1, subs[k], d);
      check({15'h0, rsp.nack}, 16'h0);
      if (subs[k] inside {SUB_NARROW_A, SUB_NARROW_B, SUB_NARROW_C, SUB_NARROW_D})
        d = {8'h00, d[7:0]};
      check(dev.mem[subs[k][3:0]], d);
    end
  endtask
  task rd_regs(input logic m3);
    run(m3, 1'b0, RD_SUB_STATUS, 16'h0);
    check({8'h00, rsp.data}, {8'h00, STAT_V});
    run(m3, 1'b0, RD_SUB_ADC, 16'h0);
    check({7'h0, rsp.nack, rsp.data}, {8'h00, ADC_V});
  endtask
  task nack_addr;
    logic [15:0] keep;
    keep = dev.mem[0];
    mute = 1;
    run(1'b0, 1'b1, 8'h00, ~keep);
    check({15'h0, rsp.nack}, 16'h1);
    check(dev.mem[0], keep);
    mute = 0;
  endtask
  task unmapped;
    run(1'b0, 1'b1, 8'h0a, 16'hffff);
    check({15'h0, rsp.nack}, 16'h0);
    check(dev.mem[10], 16'h0000);
  endtask
  initial begin
    reset = 1; mode_3wire = 0; cmd_valid = 0; cmd = '0; mute = 0;
    mismatches = 0; n_tests = 0;
    repeat (2) @(negedge sys_clk);
    reset = 0;
    repeat (3) @(negedge sys_clk);
    wr_burst(1'b0);
    rd_regs(1'b0);
    nack_addr();
    unmapped();
    wr_burst(1'b1);
    rd_regs(1'b1);
    rd_regs(1'b0);
    final_report();
  end
endmodule
